// ===== bank_regs.sv
// Duplicated general registers, two banks of eight words.
// Assumes writes and reads in the same clock domain.
`timescale 1ns/10ps
module bank_regs #(
   parameter int W = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);

   logic [W-1:0] mem [0:(1<<AW)-1];

   // Read data leaves through a register
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule // bank_regs

// ===== irq_ctl_model.sv
// Interrupt controller stand-in.
// Assumes the bench raises go for as long as it wants a request.
`timescale 1ns/10ps
module irq_ctl_model (
   input wire logic hclk,
   input wire logic go,
   input wire logic irq_accept,
   output logic irq_req,
   output logic irq_ack,
   output logic irq_hw
);
   // *****
   // Request and acknowledge
   // *****
   assign irq_hw = 1'b1;
   // One ack per accepted request, then withdraw
   always @(posedge hclk) begin
      irq_ack <= irq_req & irq_accept & !irq_ack;
      irq_req <= go & !irq_ack;
   end
endmodule // irq_ctl_model

// ===== psw_checker_assertions.sv
// Checker for the status word block.
// Bound to psw_core; sees only its ports.
`timescale 1ns/10ps
module psw_checker
   import psw_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [15:0] psw,
   input wire logic [15:0] saved_psw,
   input wire logic bank_sel,
   input wire logic stack_sel,
   input wire logic irq_accept,
   input wire logic irq_req,
   input wire logic [2:0] irq_prio,
   input wire logic irq_maskable,
   input wire logic irq_ack,
   input wire logic irq_hw,
   input wire logic step_req,
   input wire logic instr_done,
   input wire logic alu_wr,
   input wire logic [3:0] alu_flag_mask,
   input wire logic [15:0] alu_result,
   input wire logic alu_byte,
   input wire logic alu_carry,
   input wire logic swint,
   input wire logic [5:0] swint_vec
);
   // *****
   // Properties
   // *****
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence ack_s;
      irq_ack;
   endsequence
   sequence zw_s;
      alu_wr && alu_flag_mask[1] && !alu_byte;
   endsequence
   sequence swl_s;
      swint && (swint_vec < SWINT_LOW_LIMIT);
   endsequence
   sequence cw_s;
      alu_wr && alu_flag_mask[0];
   endsequence
   sequence sw_s;
      alu_wr && alu_flag_mask[2] && !alu_byte;
   endsequence
   swint_stack_a: assert property (swl_s |=> !psw[U_BIT])
      else $error("stack kept on soft interrupt");
   carry_flag_a: assert property (cw_s |=> psw[C_BIT] == $past(alu_carry))
      else $error("carry flag off");
   sign_flag_a: assert property (sw_s |=> psw[S_BIT] == $past(alu_result[15]))
      else $error("sign flag off");
   resv_bits_a: assert property ((psw & ~PSW_USED) == 16'h0000)
      else $error("reserved bit set");
   bank_follow_a: assert property (bank_sel == psw[B_BIT])
      else $error("bank select off");
   stack_follow_a: assert property (stack_sel == psw[U_BIT])
      else $error("stack select off");
   step_gate_a: assert property (step_req == (psw[D_BIT] && instr_done))
      else $error("step request off");
   accept_rule_a: assert property (irq_accept == (irq_req && irq_prio > psw[IPL_LSB+:IPL_W]
      && (psw[I_BIT] || !irq_maskable))) else $error("accept off");
   ack_clear_a: assert property (ack_s |=> !psw[I_BIT] && !psw[D_BIT])
      else $error("ack left flags");
   ack_save_a: assert property (ack_s |=> saved_psw == $past(psw))
      else $error("saved word off");
   hw_stack_a: assert property (ack_s ##0 irq_hw |=> !psw[U_BIT])
      else $error("stack kept on ack");
   zero_flag_a: assert property (zw_s |=> psw[Z_BIT] == ($past(alu_result) == 16'h0000))
      else $error("zero flag off");
endmodule // psw_checker
bind psw_core psw_checker chk(.hclk, .hresetn, .psw, .saved_psw, .bank_sel, .stack_sel, .irq_accept,
   .irq_req, .irq_prio, .irq_maskable, .irq_ack, .irq_hw, .step_req, .instr_done, .alu_wr,
   .alu_flag_mask, .alu_result, .alu_byte, .alu_carry, .swint, .swint_vec);

// ===== psw_core.sv
// Processor status word with stack pointers and banked registers.
// Assumes ALU, sequencer and interrupt controller on hclk.
`timescale 1ns/10ps
module psw_core
   import psw_pkg::*;
#(
   parameter int SP_W = 16,
   parameter int REG_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic alu_wr,
   input wire logic [3:0] alu_flag_mask,
   input wire logic alu_carry,
   input wire logic alu_overflow,
   input wire logic [15:0] alu_result,
   input wire logic alu_byte,
   input wire logic seq_psw_wr,
   input wire logic [15:0] seq_psw_wdata,
   input wire logic instr_done,
   input wire logic swint,
   input wire logic [5:0] swint_vec,
   input wire logic irq_req,
   input wire logic [2:0] irq_prio,
   input wire logic irq_maskable,
   input wire logic irq_ack,
   input wire logic irq_hw,
   input wire logic sp_wr,
   input wire logic [SP_W-1:0] sp_wdata,
   input wire logic rf_we,
   input wire logic [2:0] rf_waddr,
   input wire logic [REG_W-1:0] rf_wdata,
   input wire logic [2:0] rf_raddr,
   output logic [REG_W-1:0] rf_rdata,
   output logic [15:0] psw,
   output logic [15:0] saved_psw,
   output logic bank_sel,
   output logic stack_sel,
   output logic [SP_W-1:0] sp_active,
   output logic irq_accept,
   output logic step_req,
   output logic irq_out
);

   // ****************************************
   // Elaboration checks
   // ****************************************
   if (SP_W != 16 || REG_W < 1) begin : g_bad_width
      $error("psw_core: stack pointer width must be 16");
   end
   // The status word layout is fixed by the package
   if (IPL_LSB + IPL_W > 15 || U_BIT >= IPL_LSB) begin : g_bad_layout
      $error("psw_core: priority field outside the status word");
   end
   if (EVT_W != 3) begin : g_bad_events
      $error("psw_core: three event sources are wired");
   end

   // ****************************************
   // State
   // ****************************************
   logic [15:0] psw_r, psw_nxt;
   logic [15:0] saved_r;
   logic [SP_W-1:0] irq_sp_r, task_sp_r;
   logic [SP_W-1:0] irq_sp_nxt, task_sp_nxt;
   logic [15:0] saved_nxt;
   logic [EVT_W-1:0] evt_r, evt_en_r, evt_nxt;
   logic [EVT_W-1:0] evt_en_nxt;
   logic dp_wr_r;
   logic [7:0] dp_addr_r;
   logic [31:0] hrdata_r;

   // ****************************************
   // Bus decode
   // ****************************************
   // Offset match, shared by the address and data phase decodes
   function automatic logic ofs_is(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   wire ap_valid = hsel & htrans[1] & hready;
   wire ap_word = (hsize == HSIZE_WORD);
   wire [7:0] ap_addr = haddr[7:0];
   wire hit_psw = dp_wr_r & ofs_is(dp_addr_r, OFS_PSW);
   wire hit_isp = dp_wr_r & ofs_is(dp_addr_r, OFS_IRQ_SP);
   wire hit_tsp = dp_wr_r & ofs_is(dp_addr_r, OFS_TASK_SP);
   wire hit_clr = dp_wr_r & ofs_is(dp_addr_r, OFS_EVT_CLEAR);
   wire hit_en = dp_wr_r & ofs_is(dp_addr_r, OFS_EVT_ENABLE);
   wire [15:0] bus_w16 = hwdata[15:0];

   // Zero wait states; every transfer answers OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // Flag computation
   // ****************************************
   wire [3:0] cpu_priority_level = {1'b0, psw_r[IPL_LSB +: IPL_W]};
   // Byte operations judge zero and sign on the low eight bits only
   function automatic logic res_is_zero(input logic [15:0] r, input logic byte_op);
      if (byte_op) begin
         return r[7:0] == 8'h00;
      end
      return r == 16'h0000;
   endfunction

   function automatic logic res_is_neg(input logic [15:0] r, input logic byte_op);
      if (byte_op) begin
         return r[7];
      end
      return r[15];
   endfunction

   wire res_zero = res_is_zero(alu_result, alu_byte);
   wire res_neg = res_is_neg(alu_result, alu_byte);
   wire low_swint = swint & (swint_vec < SWINT_LOW_LIMIT);
   wire int_en = psw_r[I_BIT];

   // Maskable requests need the enable bit; the level test applies to all
   assign irq_accept = irq_req & ({1'b0, irq_prio} > cpu_priority_level) & (int_en | ~irq_maskable);
   assign step_req = psw_r[D_BIT] & instr_done;

   // Later writes win: bus write, then sequencer, then ALU flags, then acknowledge, then low soft interrupt
   always_comb begin
      psw_nxt = psw_r;
      if (hit_psw) begin
         psw_nxt = bus_w16;
      end
      if (seq_psw_wr) begin
         psw_nxt = seq_psw_wdata;
      end
      if (alu_wr) begin
         if (alu_flag_mask[0]) psw_nxt[C_BIT] = alu_carry;
         if (alu_flag_mask[1]) psw_nxt[Z_BIT] = res_zero;
         if (alu_flag_mask[2]) psw_nxt[S_BIT] = res_neg;
         if (alu_flag_mask[3]) psw_nxt[O_BIT] = alu_overflow;
      end
      if (irq_ack) begin
         psw_nxt[D_BIT] = 1'b0;
         psw_nxt[I_BIT] = 1'b0;
         if (irq_hw) psw_nxt[U_BIT] = 1'b0;
      end
      if (low_swint) begin
         psw_nxt[U_BIT] = 1'b0;
      end
      psw_nxt = psw_nxt & PSW_USED;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psw_r <= PSW_RESET;
      end else begin
         psw_r <= psw_nxt;
      end
   end

   // Old word kept before the acknowledge clears bits
   assign saved_nxt = (irq_ack | swint) ? psw_r : saved_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         saved_r <= PSW_RESET;
      end else begin
         saved_r <= saved_nxt;
      end
   end

   // ****************************************
   // Stack pointers
   // ****************************************
   // The core port writes the active pointer and wins over the bus
   wire sp_wr_irq = sp_wr & ~psw_r[U_BIT];
   wire sp_wr_task = sp_wr & psw_r[U_BIT];

   always_comb begin
      irq_sp_nxt = irq_sp_r;
      task_sp_nxt = task_sp_r;
      if (hit_isp) begin
         irq_sp_nxt = bus_w16;
      end
      if (hit_tsp) begin
         task_sp_nxt = bus_w16;
      end
      if (sp_wr_irq) begin
         irq_sp_nxt = sp_wdata;
      end
      if (sp_wr_task) begin
         task_sp_nxt = sp_wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_sp_r <= SP_RESET;
         task_sp_r <= SP_RESET;
      end else begin
         irq_sp_r <= irq_sp_nxt;
         task_sp_r <= task_sp_nxt;
      end
   end

   // ****************************************
   // Banked registers
   // ****************************************
   // Bank bit forms the top address bit, so a switch needs no copy
   bank_regs #(
      .W(REG_W),
      .AW(4)
   ) u_bank_regs (
      .clk(hclk),
      .we(rf_we),
      .waddr({psw_r[B_BIT], rf_waddr}),
      .wdata(rf_wdata),
      .raddr({psw_r[B_BIT], rf_raddr}),
      .rdata(rf_rdata)
   );

   // ****************************************
   // Event flags
   // ****************************************
   wire [EVT_W-1:0] evt_set = {alu_wr & alu_flag_mask[3] & alu_overflow, irq_accept, step_req};
   wire [EVT_W-1:0] evt_clr = hit_clr ? hwdata[EVT_W-1:0] : {EVT_W{1'b0}};

   // A set in the cycle of its clear wins
   assign evt_nxt = (evt_r & ~evt_clr) | evt_set;
   assign evt_en_nxt = hit_en ? hwdata[EVT_W-1:0] : evt_en_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_r <= '0;
         evt_en_r <= '0;
      end else begin
         evt_r <= evt_nxt;
         evt_en_r <= evt_en_nxt;
      end
   end

   assign irq_out = |(evt_r & evt_en_r);

   // ****************************************
   // Bus data phase and read mux
   // ****************************************
   // Next values, so a read right behind a write to the same register sees it
   wire [31:0] rd_mux =
      ofs_is(ap_addr, OFS_PSW) ? {16'h0000, psw_nxt} :
      ofs_is(ap_addr, OFS_IRQ_SP) ? {16'h0000, irq_sp_nxt} :
      ofs_is(ap_addr, OFS_TASK_SP) ? {16'h0000, task_sp_nxt} :
      ofs_is(ap_addr, OFS_SAVED) ? {16'h0000, saved_nxt} :
      ofs_is(ap_addr, OFS_EVT_STATUS) ? {29'h0000_0000, evt_nxt} :
      ofs_is(ap_addr, OFS_EVT_ENABLE) ? {29'h0000_0000, evt_en_nxt} : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else begin
         dp_wr_r <= ap_valid & hwrite & ap_word;
         dp_addr_r <= ap_addr;
         if (ap_valid & ~hwrite) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   assign hrdata = hrdata_r;

   // ****************************************
   // Outputs
   // ****************************************
   assign psw = psw_r;
   assign saved_psw = saved_r;
   assign bank_sel = psw_r[B_BIT];
   assign stack_sel = psw_r[U_BIT];
   assign sp_active = psw_r[U_BIT] ? task_sp_r : irq_sp_r;

endmodule // psw_core

// ===== psw_pkg.sv
// Constants for the processor status word block.
// Assumes one 50 MHz clock and an AHB-Lite register bus.
package psw_pkg;

   // ****************************************
   // Status word layout
   // ****************************************
   localparam int C_BIT = 0;
   localparam int D_BIT = 1;
   localparam int Z_BIT = 2;
   localparam int S_BIT = 3;
   localparam int B_BIT = 4;
   localparam int O_BIT = 5;
   localparam int I_BIT = 6;
   localparam int U_BIT = 7;
   localparam int IPL_LSB = 12;
   localparam int IPL_W = 3;
   localparam logic [15:0] PSW_USED = 16'h70ff;
   localparam logic [15:0] PSW_RESET = 16'h0000;
   localparam logic [5:0] SWINT_LOW_LIMIT = 6'h20;

   // ****************************************
   // Register map, byte offsets
   // ****************************************
   localparam logic [7:0] OFS_PSW = 8'h00;
   localparam logic [7:0] OFS_IRQ_SP = 8'h04;
   localparam logic [7:0] OFS_TASK_SP = 8'h08;
   localparam logic [7:0] OFS_SAVED = 8'h0c;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h14;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h18;
   localparam int EVT_W = 3;
   localparam int EVT_STEP = 0;
   localparam int EVT_ACCEPT = 1;
   localparam int EVT_OVF = 2;
   localparam logic [15:0] SP_RESET = 16'h0000;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// ===== tb_cpu_processor_status_word.sv
// Bench for the status word block.
// Assumes zero-wait bus answers and the controller model.
`timescale 1ns/10ps
module tb_cpu_processor_status_word
   import psw_pkg::*;
();
   // *****
   // Stimulus and checks
   // *****
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, irq_maskable = 1;
   logic alu_wr = 0, alu_carry = 0, alu_overflow = 0, alu_byte = 0, seq_psw_wr = 0;
   logic instr_done = 0, swint = 0, sp_wr = 0, rf_we = 0;
   logic [2:0] rf_waddr = 3'h0, rf_raddr = 3'h0;
   logic [15:0] rf_wdata = 16'h0000, rf_rdata;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2, irq_prio = 0;
   logic [3:0] alu_flag_mask = 4'hf;
   logic [15:0] alu_result = 0, seq_psw_wdata = 0, sp_wdata = 0, psw, saved_psw, sp_active;
   logic [5:0] swint_vec = 0;
   logic hreadyout, hresp, irq_req, irq_ack, irq_hw, bank_sel, stack_sel, irq_accept, step_req, irq_out;
   int miscompares = 0, total_checks = 0;
   always #10 hclk = ~hclk;
   psw_core dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .alu_wr, .alu_flag_mask, .alu_carry, .alu_overflow, .alu_result,
      .alu_byte, .seq_psw_wr, .seq_psw_wdata, .instr_done, .swint, .swint_vec, .irq_req, .irq_prio,
      .irq_maskable, .irq_ack, .irq_hw, .sp_wr, .sp_wdata, .rf_we, .rf_waddr,
      .rf_wdata, .rf_raddr, .rf_rdata, .psw, .saved_psw, .bank_sel, .stack_sel,
      .sp_active, .irq_accept, .step_req, .irq_out);
   irq_ctl_model ctl(.hclk, .go, .irq_accept, .irq_req, .irq_ack, .irq_hw);
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bounded wait for hready
   task automatic wt();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
      q = hrdata;
   endtask
   task automatic s_regs();
      chk("psw", 0, psw);
      bus(OFS_PSW, 1, 32'hffff_ffff);
      bus(OFS_PSW, 0, 0);
      chk("psw rd", 32'h0000_70ff, q);
      chk("hresp", 0, hresp);
      chk("bank", 1, bank_sel);
      chk("stack", 1, stack_sel);
      sp_wr <= 1'b1;
      sp_wdata <= 16'h1234;
      @(posedge hclk);
      sp_wr <= 1'b0;
      bus(OFS_TASK_SP, 0, 0);
      chk("task sp", 32'h0000_1234, q);
      chk("sp act", 32'h0000_1234, sp_active);
      bus(OFS_IRQ_SP, 0, 0);
      chk("irq sp", 0, q);
      bus(8'h1c, 0, 0);
      chk("unmapped", 0, q);
   endtask
   task automatic s_alu();
      logic [15:0] r [3] = '{16'h0000, 16'h8000, 16'h0100};
      bus(OFS_PSW, 1, 0);
      for (int i = 0; i < 3; i++) begin
         alu_result <= r[i];
         alu_carry <= i[0];
         alu_overflow <= (i == 1);
         alu_byte <= (i == 2);
         alu_wr <= 1'b1;
         @(posedge hclk);
         alu_wr <= 1'b0;
         repeat (2) @(posedge hclk);
         chk("flags", {10'h000, i == 1, 1'b0, i == 1, i != 1, 1'b0, i[0]}, psw);
      end
      alu_overflow <= 1'b0;
   endtask
   task automatic s_irq();
      logic [31:0] w;
      bus(OFS_EVT_CLEAR, 1, 32'h0000_0007);
      bus(OFS_EVT_ENABLE, 1, 32'h0000_0002);
      for (int p = 0; p < 8; p++) begin
         w = p == 7 ? 32'h0000_3082 : 32'h0000_30c2;
         bus(OFS_PSW, 1, w);
         irq_maskable <= (p != 7);
         irq_prio <= p[2:0];
         go <= 1'b1;
         repeat (5) @(posedge hclk);
         go <= 1'b0;
         @(posedge hclk);
         chk("psw irq", p > 3 ? 32'h0000_3000 : w, psw);
         if (p > 3)
            chk("saved", w, saved_psw);
      end
      chk("irq out", 1, irq_out);
      bus(OFS_EVT_ENABLE, 1, 0);
      repeat (2) @(posedge hclk);
      chk("masked", 0, irq_out);
      bus(OFS_EVT_STATUS, 0, 0);
      chk("status", 32'h0000_0002, q);
      bus(OFS_EVT_ENABLE, 1, 32'h0000_0002);
      bus(OFS_EVT_CLEAR, 1, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      chk("cleared", 0, irq_out);
   endtask
   task automatic s_swint();
      seq_psw_wr <= 1'b1;
      seq_psw_wdata <= 16'h0082;
      @(posedge hclk);
      seq_psw_wr <= 1'b0;
      instr_done <= 1'b1;
      @(negedge hclk);
      chk("step", 1, step_req);
      @(posedge hclk);
      instr_done <= 1'b0;
      for (int v = 31; v < 33; v++) begin
         seq_psw_wr <= 1'b1;
         seq_psw_wdata <= 16'h0080;
         @(posedge hclk);
         seq_psw_wr <= 1'b0;
         swint <= 1'b1;
         swint_vec <= v[5:0];
         @(posedge hclk);
         swint <= 1'b0;
         @(posedge hclk);
         chk("stack sel", v == 32, psw[U_BIT]);
      end
   endtask
   task automatic s_bank();
      seq_psw_wr <= 1'b1;
      seq_psw_wdata <= 16'h0000;
      rf_waddr <= 3'h3;
      rf_raddr <= 3'h3;
      @(posedge hclk);
      seq_psw_wr <= 1'b0;
      rf_we <= 1'b1;
      rf_wdata <= 16'haaaa;
      @(posedge hclk);
      rf_we <= 1'b0;
      seq_psw_wr <= 1'b1;
      seq_psw_wdata <= 16'h0010;
      @(posedge hclk);
      seq_psw_wr <= 1'b0;
      rf_we <= 1'b1;
      rf_wdata <= 16'h5555;
      @(posedge hclk);
      rf_we <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("bank1 reg", 32'h0000_5555, rf_rdata);
      seq_psw_wr <= 1'b1;
      seq_psw_wdata <= 16'h0000;
      @(posedge hclk);
      seq_psw_wr <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("bank0 reg", 32'h0000_aaaa, rf_rdata);
   endtask
   task automatic s_reset();
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk("rst psw", 0, psw);
      chk("rst saved", 0, saved_psw);
      chk("rst sp", 0, sp_active);
      chk("rst hrdata", 0, hrdata);
      chk("rst irq", 0, irq_out);
      hresetn <= 1'b1;
      bus(OFS_TASK_SP, 0, 0);
      chk("rst task sp", 0, q);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      s_regs();
      s_alu();
      s_irq();
      s_swint();
      s_bank();
      s_reset();
      give_verdict();
   end
endmodule // tb_cpu_processor_status_word
